// ### sim/reset_selftest_sysfail_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module reset_selftest_sysfail_sequencer_tb;
    import rss_pkg::*;
    logic             clk = 1'b0, srst = 1'b1, backplane_reset_n = 1'b1;
    logic             soft_reset_bit = 1'b0, test_cmd = 1'b0, sysfail_inhibit = 1'b0;
    logic             power_5v_ok = 1'b1, mute = 1'b0, pass_iface = 1'b1, pass_instr = 1'b1;
    logic [3:0]       upper_address_switch = 4'h0, lower_address_switch = 4'h0;
    logic [ERR_W-1:0] err = '0, acc, error_record;
    logic [7:0]       la;
    rss_result_t      iface_result, instr_result;
    logic             sysfail_n_o, sysfail_n_oe, failure_indicator, inputs_isolated;
    logic             iface_test_start, instr_test_start, defaults_restore, ready;
    logic             dynamic_config;
    logic [15:0]      base_address;
    int               mismatches = 0;
    int               n_compared = 0;
    string            nm[4] = '{"ready", "sysfail_n_oe", "instr_test_start", "defaults_restore"};

    always #25 clk = ~clk;

    rss_sequencer #(.TEST_LIMIT(200)) u_rss_sequencer (
        .clk                  (clk),
        .srst                 (srst),
        .upper_address_switch (upper_address_switch),
        .lower_address_switch (lower_address_switch),
        .backplane_reset_n    (backplane_reset_n),
        .soft_reset_bit       (soft_reset_bit),
        .test_cmd             (test_cmd),
        .sysfail_inhibit      (sysfail_inhibit),
        .power_5v_ok          (power_5v_ok),
        .iface_result         (iface_result),
        .instr_result         (instr_result),
        .sysfail_n_o          (sysfail_n_o),
        .sysfail_n_oe         (sysfail_n_oe),
        .failure_indicator    (failure_indicator),
        .inputs_isolated      (inputs_isolated),
        .iface_test_start     (iface_test_start),
        .instr_test_start     (instr_test_start),
        .defaults_restore     (defaults_restore),
        .ready                (ready),
        .dynamic_config       (dynamic_config),
        .base_address         (base_address),
        .error_record         (error_record)
    );
    rss_test_model u_rss_test_model (.clk(clk), .srst(srst), .go_iface(iface_test_start),
        .go_instr(instr_test_start), .mute(mute), .pass_iface(pass_iface),
        .pass_instr(pass_instr), .err(err), .iface_result(iface_result),
        .instr_result(instr_result));

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    function automatic logic pick(input int k);
        case (k)
            0: return ready;
            1: return sysfail_n_oe;
            2: return instr_test_start;
            default: return defaults_restore;
        endcase
    endfunction : pick
    function automatic logic [15:0] exp_base(input logic [7:0] a);
        return 16'(int'(BASE_OFFSET) + 64 * int'(a));
    endfunction : exp_base
    // bounded poll; a miss shows up as a mismatch
    task automatic wait_for(input int k, input logic v, input int lim);
        for (int i = 0; i < lim && pick(k) !== v; i++) cyc(1);
        check(nm[k], 16'(v), 16'(pick(k)));
    endtask : wait_for
    task automatic summarize();
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    // commander may raise the inhibit in the same cycle as the reset bit
    task automatic pulse_soft(input logic inh);
        soft_reset_bit  = 1'b1;
        sysfail_inhibit = inh;
        cyc(1);
        soft_reset_bit = 1'b0;
        cyc(2);
    endtask : pulse_soft

    initial begin
        void'($urandom(72890));
        cyc(6);
        srst = 1'b0;
        cyc(1);
        check("sysfail_n_oe", 0, sysfail_n_oe);
        check("failure_indicator", 1, failure_indicator);
        check("inputs_isolated", 1, inputs_isolated);
        wait_for(0, 1, 100);
        check("sysfail_n_oe", 1, sysfail_n_oe);
        check("inputs_isolated", 0, inputs_isolated);
        for (int i = 0; i < 8; i++) begin
            la = (i == 0) ? 8'hff : (i == 1) ? 8'h0a : (i == 2) ? 8'h15 : 8'($urandom);
            {upper_address_switch, lower_address_switch} = la;
            cyc(4);
            check("dynamic_config", 16'(la == 8'hff), 16'(dynamic_config));
            if (la != 8'hff) check("base_address", exp_base(la), base_address);
        end
        acc = 8'($urandom) | 8'h01;
        err = acc;
        pass_iface = 1'b0;
        pulse_soft(1'b0);
        check("sysfail_n_oe", 0, sysfail_n_oe);
        cyc(20);
        check("sysfail_n_oe", 0, sysfail_n_oe);
        check("ready", 0, ready);
        check("error_record", 16'(acc), 16'(error_record));
        sysfail_inhibit = 1'b1;
        wait_for(1, 1, 8);
        power_5v_ok = 1'b0;
        wait_for(1, 0, 8);
        power_5v_ok = 1'b1;
        sysfail_inhibit = 1'b0;
        pass_iface = 1'b1;
        backplane_reset_n = 1'b0;
        cyc(3);
        backplane_reset_n = 1'b1;
        wait_for(3, 1, 100);
        wait_for(0, 1, 4);
        check("error_record", 0, 16'(error_record));
        acc = '0;
        pass_instr = 1'b0;
        for (int i = 0; i < 2; i++) begin
            err = 8'($urandom) | 8'h10;
            acc = acc | err;
            test_cmd = 1'b1;
            cyc(1);
            test_cmd = 1'b0;
            wait_for(2, 1, 5);
            check("inputs_isolated", 1, inputs_isolated);
            check("ready", 0, ready);
            for (int k = 0; k < 12 && defaults_restore !== 1'b1; k++) begin
                check("sysfail_n_oe", 1, sysfail_n_oe);
                check("iface_test_start", 0, iface_test_start);
                cyc(1);
            end
            check("defaults_restore", 1, 16'(defaults_restore));
            wait_for(0, 1, 4);
            check("error_record", 16'(acc), 16'(error_record));
        end
        mute = 1'b1;
        pass_instr = 1'b1;
        pulse_soft(1'b1);
        check("sysfail_n_oe", 1, sysfail_n_oe);
        check("ready", 0, ready);
        wait_for(0, 1, 260);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule : reset_selftest_sysfail_sequencer_tb
`default_nettype wire

// ### sim/rss_test_model.sv
`timescale 1ns/100ps
`default_nettype none
module rss_test_model
    import rss_pkg::*;
#(
    parameter int DLY = 6
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             go_iface,
    input  wire logic             go_instr,
    input  wire logic             mute,
    input  wire logic             pass_iface,
    input  wire logic             pass_instr,
    input  wire logic [ERR_W-1:0] err,
    output rss_result_t           iface_result,
    output rss_result_t           instr_result
);
    int iface_cnt_reg;
    int instr_cnt_reg;
    // engines answer once per start; any reset restarts the interface engine and aborts the instrument one
    always_ff @(posedge clk) begin
        iface_result <= '0;
        iface_cnt_reg <= (srst || go_iface) ? DLY : iface_cnt_reg - int'(iface_cnt_reg > 0);
        if (!srst && !go_iface && iface_cnt_reg == 1) begin
            iface_result <= '{1'b1, pass_iface, pass_iface ? '0 : err};
        end
    end
    // mute models an instrument test that hangs
    always_ff @(posedge clk) begin
        instr_result <= '0;
        instr_cnt_reg <= (srst || go_iface) ? 0 :
                         go_instr ? DLY : instr_cnt_reg - int'(instr_cnt_reg > 0);
        if (!srst && !go_iface && !mute && instr_cnt_reg == 1) begin
            instr_result <= '{1'b1, pass_instr, pass_instr ? '0 : err};
        end
    end
endmodule : rss_test_model
`default_nettype wire

// ### src/rss_pkg.sv
package rss_pkg;
    localparam int          CLK_HZ           = 20_000_000;
    localparam logic [7:0]  LA_DYNAMIC       = 8'hff;
    localparam logic [15:0] BASE_OFFSET      = 16'hc000;
    localparam int          BASE_SHIFT       = 6;
    localparam int          TEST_LIMIT_S     = 5;
    localparam int          TEST_LIMIT_CYC   = TEST_LIMIT_S * CLK_HZ;
    localparam int          ERR_W            = 8;

    typedef enum logic [2:0] {
        RSS_IDLE,
        RSS_IFACE,
        RSS_INSTR,
        RSS_CMD,
        RSS_PASSED,
        RSS_FAILED
    } rss_state_t;

    typedef struct packed {
        logic             done;
        logic             pass;
        logic [ERR_W-1:0] errors;
    } rss_result_t;
endpackage : rss_pkg

// ### src/rss_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// [R1] base address is 64 times logical address plus 49152
// [R2] switch value ffh selects dynamic logical address instead of switches
// [R3] start-up tests run interface and instrument; commanded test runs instrument only
// [R4] backplane reset line starts the reset and self-test sequence
// [R5] commander reset bit starts the reset and self-test sequence
// [R6] analog inputs isolated during power-on and any self test
// [R7] reset entry asserts system-failure line and failure indicator
// [R8] interface pass releases failure line to passed; fail keeps it, failed
// [R9] failures of any self test are recorded for later error query; code records nothing for a timed-out test
// [R10] defaults restored after reset-initiated self test; code restores none after an interface failure
// [R11] commanded self test leaves system-failure line deasserted
// [R12] commanded test restores defaults but keeps its errors queued
// [R13] inhibit from resource manager releases failure line unless +5 V lost
// [R14] reset-initiated test ends within 5 seconds; commanded test exempt
// [R15] commander should assert failure inhibit together with soft reset
// [R16] after power-on, ready for programming within five seconds; code never raises ready after an interface failure
// [R17] failure line held steadily from reset entry until interface outcome known
module rss_sequencer
    import rss_pkg::*;
#(
    parameter int TEST_LIMIT = TEST_LIMIT_CYC
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [3:0]       upper_address_switch,
    input  wire logic [3:0]       lower_address_switch,
    input  wire logic             backplane_reset_n,
    input  wire logic             soft_reset_bit,
    input  wire logic             test_cmd,
    input  wire logic             sysfail_inhibit,
    input  wire logic             power_5v_ok,
    input  wire rss_result_t      iface_result,
    input  wire rss_result_t      instr_result,
    output logic                  sysfail_n_o,
    output logic                  sysfail_n_oe,
    output logic                  failure_indicator,
    output logic                  inputs_isolated,
    output logic                  iface_test_start,
    output logic                  instr_test_start,
    output logic                  defaults_restore,
    output logic                  ready,
    output logic                  dynamic_config,
    output logic [15:0]           base_address,
    output logic [ERR_W-1:0]      error_record
);
    // pins from the backplane pass two flops first
    logic [1:0] rst_sync_reg;
    logic [1:0] inh_sync_reg;
    logic [1:0] pwr_sync_reg;
    logic       bp_rst;
    logic       inhibit;
    logic       pwr_ok;

    always_ff @(posedge clk) begin
        if (srst) begin
            rst_sync_reg <= 2'h3;
            inh_sync_reg <= 2'h0;
            pwr_sync_reg <= 2'h3;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], backplane_reset_n};
            inh_sync_reg <= {inh_sync_reg[0], sysfail_inhibit};
            pwr_sync_reg <= {pwr_sync_reg[0], power_5v_ok};
        end
    end
    assign bp_rst  = ~rst_sync_reg[1];
    assign inhibit = inh_sync_reg[1];
    assign pwr_ok  = pwr_sync_reg[1];

    // switches are static, read through the same two-flop path
    logic [7:0] la_meta_reg;
    logic [7:0] la_reg;
    always_ff @(posedge clk) begin
        la_meta_reg <= {upper_address_switch, lower_address_switch};
        la_reg      <= la_meta_reg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            base_address   <= BASE_OFFSET;
            dynamic_config <= 1'b0;
        end else begin
            base_address   <= (16'(la_reg) << BASE_SHIFT) + BASE_OFFSET; // [R1]
            dynamic_config <= (la_reg == LA_DYNAMIC); // [R2]
        end
    end

    rss_state_t  state_reg;
    logic        sysfail_reg;
    logic [31:0] timer_reg;
    logic        reset_event;
    logic        time_up;
    logic        cmd_accept;

    // power-on is the srst release itself
    assign reset_event = bp_rst || soft_reset_bit; // [R4] [R5]
    // a hung engine must not outlast the start-up limit
    assign time_up     = timer_reg >= 32'(TEST_LIMIT - 2); // [R14]
    assign cmd_accept  = (state_reg == RSS_PASSED || state_reg == RSS_IDLE) && test_cmd &&
                         !reset_event; // [R3]

    always_ff @(posedge clk) begin
        if (srst || reset_event) begin
            state_reg <= RSS_IFACE; // [R3]
        end else begin
            case (state_reg)
                RSS_IFACE: begin
                    if (iface_result.done) begin
                        state_reg <= iface_result.pass ? RSS_INSTR : RSS_FAILED; // [R8]
                    end else if (time_up) begin
                        // silent interface engine counts as failed
                        state_reg <= RSS_FAILED; // [R14]
                    end
                end
                RSS_INSTR: begin
                    // timeout forces completion within the start-up limit
                    if (instr_result.done || time_up) begin // [R14] [R16]
                        state_reg <= RSS_PASSED;
                    end
                end
                RSS_CMD: begin
                    if (instr_result.done) begin
                        state_reg <= RSS_PASSED;
                    end
                end
                RSS_PASSED, RSS_IDLE: begin
                    if (test_cmd) begin
                        state_reg <= RSS_CMD; // [R3]
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst || reset_event || state_reg == RSS_CMD) begin
            timer_reg <= 32'h0;
        end else if (state_reg == RSS_IFACE || state_reg == RSS_INSTR) begin
            timer_reg <= timer_reg + 32'h1;
        end
    end

    // failure line: set on reset, held through interface test
    always_ff @(posedge clk) begin
        if (srst) begin
            sysfail_reg <= 1'b1;
        end else if (reset_event) begin
            sysfail_reg <= 1'b1; // [R7] [R17]
        end else if (state_reg == RSS_IFACE && iface_result.done) begin
            sysfail_reg <= ~iface_result.pass; // [R8]
        end
        // rail loss acts through line_active only, so the line frees when it returns
    end

    logic line_active;
    // inhibit suppresses drive except when +5 V is lost
    assign line_active = (sysfail_reg || !pwr_ok) && !(inhibit && pwr_ok); // [R13] [R15]

    always_ff @(posedge clk) begin
        if (srst) begin
            sysfail_n_o       <= 1'b0;
            sysfail_n_oe      <= 1'b0;
            failure_indicator <= 1'b1;
        end else begin
            sysfail_n_o       <= 1'b0;
            sysfail_n_oe      <= ~line_active; // [R11] [R17]
            failure_indicator <= line_active; // [R7]
        end
    end

    logic testing;
    assign testing = (state_reg == RSS_IFACE) || (state_reg == RSS_INSTR) ||
                     (state_reg == RSS_CMD);

    always_ff @(posedge clk) begin
        if (srst) begin
            inputs_isolated  <= 1'b1;
            iface_test_start <= 1'b0;
            instr_test_start <= 1'b0;
            ready            <= 1'b0;
        end else begin
            inputs_isolated  <= testing || reset_event || cmd_accept; // [R6]
            iface_test_start <= reset_event; // [R3]
            instr_test_start <= (state_reg == RSS_IFACE && iface_result.done &&
                                 iface_result.pass && !reset_event) || cmd_accept; // [R3]
            ready            <= (state_reg == RSS_PASSED) && !reset_event && !cmd_accept; // [R16]
        end
    end

    // defaults pulse at end of an instrument or commanded test, not after an interface failure; errors survive it
    always_ff @(posedge clk) begin
        if (srst) begin
            defaults_restore <= 1'b0;
        end else begin
            defaults_restore <= !reset_event &&
                ((state_reg == RSS_INSTR && (instr_result.done ||
                  time_up)) || // [R10]
                 (state_reg == RSS_CMD && instr_result.done)); // [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            error_record <= '0;
        end else if (reset_event) begin
            error_record <= '0;
        end else if (state_reg == RSS_IFACE && iface_result.done) begin
            error_record <= error_record | iface_result.errors; // [R9]
        end else if ((state_reg == RSS_INSTR || state_reg == RSS_CMD) && instr_result.done) begin
            error_record <= error_record | instr_result.errors; // [R9] [R12]
        end
    end

    a_reset_sysfail: assert property (@(posedge clk) disable iff (srst) // [R7]
        reset_event |=> sysfail_reg) else $error("reset did not set failure");
    a_iface_pass: assert property (@(posedge clk) disable iff (srst) // [R8]
        (state_reg == RSS_IFACE && iface_result.done && iface_result.pass && !reset_event)
        |=> state_reg == RSS_INSTR && !sysfail_reg) else $error("pass mishandled");
    a_iface_fail: assert property (@(posedge clk) disable iff (srst) // [R8]
        (state_reg == RSS_IFACE && iface_result.done && !iface_result.pass && !reset_event)
        |=> state_reg == RSS_FAILED && sysfail_reg) else $error("fail mishandled");
    a_isolate_test: assert property (@(posedge clk) disable iff (srst) // [R6]
        testing |=> inputs_isolated) else $error("inputs not isolated");
    a_hold_sysfail: assert property (@(posedge clk) disable iff (srst) // [R17]
        (state_reg == RSS_IFACE && $past(state_reg) == RSS_IFACE) |-> sysfail_reg)
        else $error("failure line dropped during test");
    a_cmd_no_fail: assert property (@(posedge clk) disable iff (srst) // [R11]
        (state_reg == RSS_CMD && pwr_ok && !reset_event) |=> !sysfail_reg)
        else $error("commanded test set failure");
    a_inhibit_rel: assert property (@(posedge clk) disable iff (srst) // [R13]
        (inhibit && pwr_ok) |=> sysfail_n_oe) else $error("inhibit ignored");
    a_limit_time: assert property (@(posedge clk) disable iff (srst) // [R14]
        timer_reg < 32'(TEST_LIMIT)) else $error("start-up test too long");
    a_dyn_addr: assert property (@(posedge clk) disable iff (srst) // [R2]
        (la_reg == LA_DYNAMIC) |=> dynamic_config) else $error("dynamic not flagged");
    a_err_kept: assert property (@(posedge clk) disable iff (srst) // [R12]
        (state_reg == RSS_CMD && instr_result.done && !reset_event) |=>
        (error_record & $past(instr_result.errors)) == $past(instr_result.errors) &&
        (error_record & $past(error_record)) == $past(error_record))
        else $error("errors lost");

    sequence s_iface_ok;
        state_reg == RSS_IFACE && iface_result.done && iface_result.pass && !reset_event;
    endsequence
    // release follows the instrument start unless the rail is gone
    sequence s_release;
        instr_test_start ##1 sysfail_n_oe == $past(pwr_ok);
    endsequence
    a_pass_release: assert property (@(posedge clk) disable iff (srst) // [R8]
        s_iface_ok |=> s_release) else $error("pass did not release line");
endmodule : rss_sequencer
`default_nettype wire
